// ### rtl/tms_pkg.sv
// Shared constants, types and helpers for the temperature monitor status block
package tms_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int RC_EXTRA_MS = 125;
    localparam int RC_EXTRA_CYCLES = RC_EXTRA_MS * (CLK_HZ / 1000);
    localparam int EXTRA_W = 24;

    // Arbitrary bus address; any neutral value will do
    localparam logic [6:0] SLAVE_ADDR = 7'h2C;

    // Command codes of the three registers handled here
    localparam logic [7:0] CMD_CFG1 = 8'h12;
    localparam logic [7:0] CMD_OVT_STATUS = 8'h13;
    localparam logic [7:0] CMD_FAULT_STATUS = 8'h14;

    localparam int CFG1_STOP_BIT = 7;
    localparam int CFG1_POR_BIT = 6;
    localparam int CFG1_RC_BIT = 3;
    localparam logic [7:0] CFG1_WMASK = 8'hB8;
    localparam logic [7:0] CFG1_RESET = 8'h00;

    localparam int OVT_CH1_BIT = 0;
    localparam int OVT_CH4_BIT = 3;
    localparam logic [7:0] OVT_MASK = 8'h09;
    localparam int FAULT_CH1_BIT = 1;
    localparam logic [7:0] FAULT_MASK = 8'h1E;
    localparam logic [7:0] FAULT_UNUSED_MASK = 8'h60;

    localparam logic [1:0] CH1_IDX = 2'h0;
    localparam logic [1:0] CH4_IDX = 2'h3;

    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [8:0] HYST_DEG = 9'h004;

    typedef enum logic [2:0] {
        SMB_IDLE, SMB_ADDR, SMB_CMD, SMB_WDATA, SMB_ACK, SMB_TX, SMB_RACK
    } tms_smb_e;

    typedef enum logic [1:0] {
        SEQ_PICK, SEQ_CONV, SEQ_EXTRA
    } tms_seq_e;

    function automatic logic tms_exceeds(input logic [7:0] temp, input logic [7:0] limit);
        return temp > limit;
    endfunction : tms_exceeds

    function automatic logic tms_cooled(input logic [7:0] temp, input logic [7:0] limit);
        return ({1'b0, temp} + HYST_DEG) < {1'b0, limit};
    endfunction : tms_cooled

endpackage : tms_pkg

// ### rtl/tms_sync.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module tms_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,               // System clock
    input wire logic reset_n,             // Async reset, active low
    input wire logic [WIDTH-1:0] asyncIn, // Levels from outside the domain
    output logic [WIDTH-1:0] syncOut      // Synchronised levels
);
    logic [WIDTH-1:0] stage1_r;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1_r <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1_r <= asyncIn;
            syncOut <= stage1_r;
        end
    end
endmodule : tms_sync
`default_nettype wire

// ### rtl/tms_status_flags.sv
// Status flags, measurement sequencer and two-wire register slave of the monitor
// Function
// - Channel 4 over limit sets overtemp bit 3
// - Channel 1 over limit sets overtemp bit 0
// - Channel 4 sensor fault sets fault bit 4
// - Channel 3 sensor fault sets fault bit 3
// - Channel 2 sensor fault sets fault bit 2
// - Channel 1 sensor fault sets fault bit 1
// - Fault bits 6:5 read 0 after reset, then 1
// - Config bit 3 enables channel 1 resistance cancellation
// - Cancellation lengthens channel 1 conversion by 125ms
// - Overtemp bits clear only by status read or soft reset
// - Status read does not release overtemp pin
// - Pin releases below limit minus 4 degrees
// - Faulted channels skipped by measurement sequence
`timescale 1ns/10ps
`default_nettype none
module tms_status_flags #(
    parameter int RC_EXTRA = tms_pkg::RC_EXTRA_CYCLES
) (
    input wire logic clock,              // 100 MHz system clock
    input wire logic reset_n,            // Async reset, active low
    input wire logic smbClk,             // Bus clock pin
    input wire logic smbDataIn,          // Bus data pin level
    output logic smbDataOut,             // Bus data drive value (always 0)
    output logic smbDataOe,              // Bus data pull-down enable
    input wire logic [3:0] sensorFault,  // Per-channel open/anode-high detector
    input wire logic convDone,           // Converter result ready pulse
    input wire logic [7:0] convResult,   // Converter temperature result
    input wire logic [7:0] ch1OvtLimit,  // Channel 1 overtemp limit
    input wire logic [7:0] ch4OvtLimit,  // Channel 4 overtemp limit
    output logic convStart,              // Start conversion pulse
    output logic [1:0] convChannel,      // Channel index 0..3 for ch1..ch4
    output logic rcEnable,               // Series-resistance cancellation on
    output logic overtempOutput,         // Overtemp pin drive value (always 0)
    output logic overtempOutputOe        // Overtemp pin pull-down enable
);
    import tms_pkg::*;

    logic [5:0] syncOut;
    tms_sync #(.WIDTH(6)) uSync (
        .clock(clock),
        .reset_n(reset_n),
        .asyncIn({sensorFault, smbDataIn, smbClk}),
        .syncOut(syncOut)
    );

    wire sclS = syncOut[0];
    wire sdaS = syncOut[1];
    wire [3:0] faultS = syncOut[5:2];

    tms_smb_e smbState_r, smbState_nxt, ackNext_r, ackNext_nxt;
    tms_seq_e seqState_r, seqState_nxt;
    logic sclPrev_r, sdaPrev_r, sdaOe_r, sdaOe_nxt;
    logic [3:0] bitCnt_r, bitCnt_nxt;
    logic [7:0] shift_r, shift_nxt, txShift_r, txShift_nxt, ptr_r, ptr_nxt;
    logic [7:0] cfg1_r, result_r;
    logic [1:0] chan_r, chan_nxt, ovtStatus_r, ovtActive_r;
    logic [3:0] faultSt_r;
    logic unusedSet_r;
    logic [EXTRA_W-1:0] extraCnt_r, extraCnt_nxt;

    // Bus conditions on the synchronised pins
    wire sclRise = sclS & ~sclPrev_r;
    wire sclFall = ~sclS & sclPrev_r;
    wire startCond = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
    wire stopCond = sclS & sclPrev_r & ~sdaPrev_r & sdaS;
    wire rxState = (smbState_r == SMB_ADDR) | (smbState_r == SMB_CMD)
        | (smbState_r == SMB_WDATA);
    wire byteDone = rxState & sclFall & (bitCnt_r == BYTE_BITS);
    wire addrHit = shift_r[7:1] == SLAVE_ADDR;
    wire rdAddr = (smbState_r == SMB_ADDR) & byteDone & addrHit & shift_r[0];
    wire loadTx = rdAddr | ((smbState_r == SMB_RACK) & sclFall);
    wire regWrite = (smbState_r == SMB_WDATA) & byteDone;
    wire cfgWrite = regWrite & (ptr_r == CMD_CFG1);
    wire softReset = cfgWrite & shift_r[CFG1_POR_BIT];
    wire ovtReadClr = loadTx & (ptr_r == CMD_OVT_STATUS);

    // Reserved positions are never stored, so they read 0
    wire [7:0] ovtRead = (8'(ovtStatus_r[1]) << OVT_CH4_BIT)
        | (8'(ovtStatus_r[0]) << OVT_CH1_BIT);
    wire [7:0] faultRead = (8'(faultSt_r) << FAULT_CH1_BIT)
        | (unusedSet_r ? FAULT_UNUSED_MASK : 8'h00);
    wire [7:0] readData = (ptr_r == CMD_CFG1) ? cfg1_r
        : (ptr_r == CMD_OVT_STATUS) ? ovtRead
        : (ptr_r == CMD_FAULT_STATUS) ? faultRead : 8'h00;

    // Sequencer decode
    wire stopBit = cfg1_r[CFG1_STOP_BIT];
    wire rcOn = cfg1_r[CFG1_RC_BIT];
    wire chanFault = faultS[chan_r];
    wire needExtra = (chan_r == CH1_IDX) & rcOn;
    wire pickSkip = (seqState_r == SEQ_PICK) & ~stopBit & chanFault;
    wire pickGo = (seqState_r == SEQ_PICK) & ~stopBit & ~chanFault;
    wire convEnd = (seqState_r == SEQ_CONV) & convDone;
    wire extraEnd = (seqState_r == SEQ_EXTRA) & (extraCnt_r == '0);
    wire evalNow = (convEnd & ~needExtra) | extraEnd;
    wire [7:0] evalTemp = (seqState_r == SEQ_EXTRA) ? result_r : convResult;
    wire on1 = evalNow & (chan_r == CH1_IDX);
    wire on4 = evalNow & (chan_r == CH4_IDX);
    wire hit1 = on1 & tms_exceeds(evalTemp, ch1OvtLimit);
    wire hit4 = on4 & tms_exceeds(evalTemp, ch4OvtLimit);
    wire cool1 = on1 & tms_cooled(evalTemp, ch1OvtLimit);
    wire cool4 = on4 & tms_cooled(evalTemp, ch4OvtLimit);

    always_comb
    begin
        smbState_nxt = smbState_r;
        ackNext_nxt = ackNext_r;
        bitCnt_nxt = bitCnt_r;
        shift_nxt = shift_r;
        txShift_nxt = txShift_r;
        ptr_nxt = ptr_r;
        sdaOe_nxt = sdaOe_r;
        if (stopCond)
        begin
            smbState_nxt = SMB_IDLE;
            sdaOe_nxt = 1'b0;
        end
        else if (startCond)
        begin
            smbState_nxt = SMB_ADDR;
            bitCnt_nxt = 4'h0;
            sdaOe_nxt = 1'b0;
        end
        else
        begin
            unique case (smbState_r)
                SMB_IDLE: ;
                SMB_ADDR, SMB_CMD, SMB_WDATA:
                begin
                    if (sclRise && bitCnt_r != BYTE_BITS)
                    begin
                        shift_nxt = {shift_r[6:0], sdaS};
                        bitCnt_nxt = bitCnt_r + 4'h1;
                    end
                    if (byteDone)
                    begin
                        bitCnt_nxt = 4'h0;
                        smbState_nxt = SMB_ACK;
                        sdaOe_nxt = 1'b1;
                        if (smbState_r == SMB_ADDR)
                        begin
                            ackNext_nxt = shift_r[0] ? SMB_TX : SMB_CMD;
                            txShift_nxt = readData;
                            if (!addrHit)
                            begin
                                smbState_nxt = SMB_IDLE;
                                sdaOe_nxt = 1'b0;
                            end
                        end
                        else if (smbState_r == SMB_CMD)
                        begin
                            ptr_nxt = shift_r;
                            ackNext_nxt = SMB_WDATA;
                        end
                        else
                            ackNext_nxt = SMB_WDATA;
                    end
                end
                SMB_ACK:
                begin
                    if (sclFall)
                    begin
                        smbState_nxt = ackNext_r;
                        sdaOe_nxt = (ackNext_r == SMB_TX) & ~txShift_r[7];
                    end
                end
                SMB_TX:
                begin
                    if (sclFall && bitCnt_r == LAST_BIT)
                    begin
                        smbState_nxt = SMB_RACK;
                        sdaOe_nxt = 1'b0;
                        bitCnt_nxt = 4'h0;
                    end
                    else if (sclFall)
                    begin
                        txShift_nxt = {txShift_r[6:0], 1'b0};
                        sdaOe_nxt = ~txShift_r[6];
                        bitCnt_nxt = bitCnt_r + 4'h1;
                    end
                end
                SMB_RACK:
                begin
                    // Master acked: send the same register again
                    if (sclRise && sdaS)
                        smbState_nxt = SMB_IDLE;
                    else if (sclFall)
                    begin
                        smbState_nxt = SMB_TX;
                        txShift_nxt = readData;
                        sdaOe_nxt = ~readData[7];
                    end
                end
                default: smbState_nxt = SMB_IDLE;
            endcase
        end
    end

    always_comb
    begin
        seqState_nxt = seqState_r;
        chan_nxt = chan_r;
        extraCnt_nxt = extraCnt_r;
        unique case (seqState_r)
            SEQ_PICK:
            begin
                if (pickSkip)
                    chan_nxt = chan_r + 2'h1;
                else if (pickGo)
                    seqState_nxt = SEQ_CONV;
            end
            SEQ_CONV:
            begin
                if (convEnd && needExtra)
                begin
                    seqState_nxt = SEQ_EXTRA;
                    extraCnt_nxt = EXTRA_W'(RC_EXTRA - 1);
                end
                else if (convEnd)
                begin
                    seqState_nxt = SEQ_PICK;
                    chan_nxt = chan_r + 2'h1;
                end
            end
            SEQ_EXTRA:
            begin
                if (extraEnd)
                begin
                    seqState_nxt = SEQ_PICK;
                    chan_nxt = chan_r + 2'h1;
                end
                else
                    extraCnt_nxt = extraCnt_r - EXTRA_W'(1);
            end
            default: seqState_nxt = SEQ_PICK;
        endcase
        if (softReset)
        begin
            seqState_nxt = SEQ_PICK;
            chan_nxt = CH1_IDX;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            smbState_r <= SMB_IDLE;
            ackNext_r <= SMB_IDLE;
            sclPrev_r <= 1'b0;
            sdaPrev_r <= 1'b0;
            bitCnt_r <= 4'h0;
            shift_r <= 8'h00;
            txShift_r <= 8'h00;
            ptr_r <= 8'h00;
            sdaOe_r <= 1'b0;
            seqState_r <= SEQ_PICK;
            chan_r <= CH1_IDX;
            extraCnt_r <= '0;
        end
        else
        begin
            smbState_r <= smbState_nxt;
            ackNext_r <= ackNext_nxt;
            sclPrev_r <= sclS;
            sdaPrev_r <= sdaS;
            bitCnt_r <= bitCnt_nxt;
            shift_r <= shift_nxt;
            txShift_r <= txShift_nxt;
            ptr_r <= ptr_nxt;
            sdaOe_r <= sdaOe_nxt;
            seqState_r <= seqState_nxt;
            chan_r <= chan_nxt;
            extraCnt_r <= extraCnt_nxt;
        end
    end

    // Status, configuration and pins; soft reset acts like power-on
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg1_r <= CFG1_RESET;
            ovtStatus_r <= 2'b00;
            ovtActive_r <= 2'b00;
            faultSt_r <= 4'h0;
            unusedSet_r <= 1'b0;
            result_r <= 8'h00;
            convStart <= 1'b0;
            convChannel <= CH1_IDX;
            rcEnable <= 1'b0;
            smbDataOut <= 1'b0;
            smbDataOe <= 1'b0;
            overtempOutput <= 1'b0;
            overtempOutputOe <= 1'b0;
        end
        else
        begin
            cfg1_r <= softReset ? CFG1_RESET : cfgWrite ? (shift_r & CFG1_WMASK) : cfg1_r;
            // Set wins over the read clear; only a read or soft reset clears
            ovtStatus_r <= softReset ? 2'b00
                : ({hit4, hit1} | (ovtStatus_r & {2{~ovtReadClr}}));
            // Pin follows the condition, never the status read
            ovtActive_r <= softReset ? 2'b00
                : ({hit4, hit1} | (ovtActive_r & ~{cool4, cool1}));
            faultSt_r <= softReset ? 4'h0
                : pickSkip ? (faultSt_r | (4'h1 << chan_r))
                : pickGo ? (faultSt_r & ~(4'h1 << chan_r)) : faultSt_r;
            unusedSet_r <= ~softReset;
            result_r <= convEnd ? convResult : result_r;
            convStart <= pickGo & ~softReset;
            convChannel <= pickGo ? chan_r : convChannel;
            rcEnable <= rcOn;
            smbDataOut <= 1'b0;
            smbDataOe <= sdaOe_r;
            overtempOutput <= 1'b0;
            overtempOutputOe <= |ovtActive_r;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // A read or soft reset right after the set may clear it legally
    AST_OVT1_SET: assert property (hit1 && !softReset |=> ovtStatus_r[0]
        ##1 (ovtStatus_r[0] || $past(ovtReadClr) || $past(softReset)))
        else $error("Channel 1 overtemp flag not set and held");
    AST_OVT4_SET: assert property (hit4 && !softReset |=> ovtRead[OVT_CH4_BIT])
        else $error("Channel 4 overtemp flag not set");
    AST_FAULT_SET: assert property (pickSkip && !softReset |=> faultSt_r[$past(chan_r)]
        && !convStart)
        else $error("Faulted channel not flagged or was converted");
    AST_UNUSED_ONES: assert property (!softReset |=> faultRead[6:5] == 2'b11)
        else $error("Unused fault bits not reading one");
    AST_RC_OUT: assert property (cfgWrite && !softReset |=> ##1 rcEnable == $past(shift_r[CFG1_RC_BIT], 2))
        else $error("Cancellation enable does not follow config bit");
    // Soft reset legally cuts the extra wait short
    AST_RC_EXTRA: assert property (disable iff (!reset_n || softReset)
        convEnd && needExtra |=> seqState_r == SEQ_EXTRA [*8])
        else $error("Channel 1 extra conversion time not applied");
    AST_RESERVED: assert property ((ovtRead & ~OVT_MASK) == 8'h00
        && (faultRead & ~(FAULT_MASK | FAULT_UNUSED_MASK)) == 8'h00)
        else $error("Reserved status bit reads one");
    AST_SOFT_RST: assert property (softReset |=> ovtStatus_r == 2'b00 && faultSt_r == 4'h0
        && !unusedSet_r && ovtActive_r == 2'b00)
        else $error("Soft reset left status set");
    AST_OVT_HOLD: assert property (ovtStatus_r[0] && !ovtReadClr && !softReset |=> ovtStatus_r[0])
        else $error("Overtemp flag cleared without a read");
    AST_PIN_HOLD: assert property (ovtReadClr && ovtActive_r != 2'b00 && !cool1 && !cool4
        && !softReset |=> ##1 overtempOutputOe)
        else $error("Status read released overtemp pin");
    AST_PIN_FALL: assert property ($fell(overtempOutputOe) |-> $past(cool1 || cool4 || softReset, 2))
        else $error("Overtemp pin released without cooling");
endmodule : tms_status_flags
`default_nettype wire

// ### tb/tms_smb_host.sv
// Two-wire bus host model with a 125 ns bit period
`timescale 1ns/10ps
`default_nettype none
module tms_smb_host (
    output logic smbClk,      // Bus clock, idles high between frames
    output logic sdaDrv,      // Host data drive, 1 releases to the pull-up
    input wire logic sdaLine  // Resolved data wire
);
    localparam realtime Q = 31.25;

    initial
    begin
        smbClk = 1'b1;
        sdaDrv = 1'b1;
    end

    // Serves as first and repeated start alike
    task automatic start_cond();
        #Q sdaDrv = 1'b1;
        #Q smbClk = 1'b1;
        #Q sdaDrv = 1'b0;
        #Q smbClk = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        #Q sdaDrv = 1'b0;
        #Q smbClk = 1'b1;
        #Q sdaDrv = 1'b1;
        #Q;
    endtask : stop_cond

    // Data moves mid-low, sampled in the middle of the high phase
    task automatic bit_io(input logic b, output logic r);
        #Q sdaDrv = b;
        #Q smbClk = 1'b1;
        #Q r = sdaLine;
        #Q smbClk = 1'b0;
    endtask : bit_io

    task automatic byte_io(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
                           output logic ackOut);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], b);
            q[i] = b;
        end
        bit_io(ackIn, ackOut);
    endtask : byte_io

    task automatic write_reg(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] d,
                             output logic ok);
        logic [7:0] q;
        logic n0, n1, n2;
        start_cond();
        byte_io({a, 1'b0}, 1'b1, q, n0);
        byte_io(cmd, 1'b1, q, n1);
        byte_io(d, 1'b1, q, n2);
        stop_cond();
        ok = ~(n0 | n1 | n2);
    endtask : write_reg

    // Read byte: pointer write, repeated start, one byte, host not-acknowledge
    task automatic read_reg(input logic [6:0] a, input logic [7:0] cmd, output logic [7:0] d,
                            output logic ok);
        logic [7:0] q;
        logic n0, n1, n2, n3;
        start_cond();
        byte_io({a, 1'b0}, 1'b1, q, n0);
        byte_io(cmd, 1'b1, q, n1);
        start_cond();
        byte_io({a, 1'b1}, 1'b1, q, n2);
        byte_io(8'hFF, 1'b1, d, n3);
        stop_cond();
        ok = ~(n0 | n1 | n2);
    endtask : read_reg
endmodule : tms_smb_host
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the status flag block with a converter and sequence model
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import tms_pkg::*;
    localparam int RC_X = 20;
    localparam int LIMIT = 80000;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic smbClk, sdaDrv, smbDataOut, smbDataOe, convStart, rcEnable;
    logic overtempOutput, overtempOutputOe;
    logic [1:0] convChannel;
    wire logic sdaLine;
    logic [3:0] sensorFault = 4'h0;
    logic convDone = 1'b0;
    logic [7:0] convResult = 8'h00;
    logic [7:0] ch1Lim = 8'h00;
    logic [7:0] ch4Lim = 8'h00;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int res[4];
    int lastCh = 3, cnt = 0, busy = 0, nStarts = 0, doneAt = 0, lastGap = 0;
    logic [7:0] expOvt = 8'h00;
    logic act1 = 1'b0, act4 = 1'b0;
    logic [3:0] faultReq = 4'h0;
    bit softPending = 1'b0;

    always #5 clock = ~clock;
    // Pull-up wire: low if either party pulls
    assign sdaLine = sdaDrv & ~smbDataOe;

    tms_status_flags #(.RC_EXTRA(RC_X)) i_dut (
        .clock(clock), .reset_n(reset_n), .smbClk(smbClk), .smbDataIn(sdaLine),
        .smbDataOut(smbDataOut), .smbDataOe(smbDataOe), .sensorFault(sensorFault),
        .convDone(convDone), .convResult(convResult), .ch1OvtLimit(ch1Lim),
        .ch4OvtLimit(ch4Lim), .convStart(convStart), .convChannel(convChannel),
        .rcEnable(rcEnable), .overtempOutput(overtempOutput),
        .overtempOutputOe(overtempOutputOe)
    );
    tms_smb_host i_host (.smbClk(smbClk), .sdaDrv(sdaDrv), .sdaLine(sdaLine));

    task automatic conclude();
        if (failures == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    function automatic int next_ch(input int from, input logic [3:0] flt);
        int c;
        c = from;
        for (int i = 0; i < 4; i++)
        begin
            c = (c + 1) % 4;
            if (!flt[c])
                return c;
        end
        return c;
    endfunction : next_ch

    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] v;
        logic ok;
        i_host.read_reg(SLAVE_ADDR, cmd, v, ok);
        check({7'h0, ok}, 8'h01, "read acknowledge");
        check(v, exp, "read data");
    endtask : rd

    task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
        logic ok;
        i_host.write_reg(SLAVE_ADDR, cmd, d, ok);
        check({7'h0, ok}, 8'h01, "write acknowledge");
    endtask : wr

    task automatic wait_starts(input int k);
        int n0;
        n0 = nStarts;
        while (nStarts < n0 + k)
            @(posedge clock);
    endtask : wait_starts

    // Converter model; a fresh start always restarts it, as after a soft reset
    always @(posedge clock)
    begin
        cycles++;
        if (convDone === 1'b1)
            convDone <= #1 1'b0;
        if (convStart === 1'b1)
        begin
            if (!softPending)
            begin
                check({6'h0, convChannel}, 8'(next_ch(lastCh, sensorFault)), "channel");
                if (lastCh == 0)
                    lastGap = cycles - doneAt;
            end
            lastCh = int'(convChannel);
            nStarts++;
            busy = 1;
            cnt = 4 + int'($urandom % 6);
            sensorFault <= #1 faultReq;
        end
        else if (busy == 1)
        begin
            cnt--;
            if (cnt == 1)
            begin
                check({7'h0, overtempOutputOe}, {7'h0, act1 | act4}, "pin");
                check({6'h0, smbDataOut, overtempOutput}, 8'h00, "drive values");
            end
            if (cnt == 0)
            begin
                busy = 0;
                doneAt = cycles;
                convDone <= #1 1'b1;
                convResult <= #1 8'(res[lastCh]);
                if (lastCh == 0 && res[0] > int'(ch1Lim))
                    {expOvt[0], act1} = 2'b11;
                else if (lastCh == 0 && res[0] + 4 < int'(ch1Lim))
                    act1 = 1'b0;
                if (lastCh == 3 && res[3] > int'(ch4Lim))
                    {expOvt[3], act4} = 2'b11;
                else if (lastCh == 3 && res[3] + 4 < int'(ch4Lim))
                    act4 = 1'b0;
            end
        end
        // Last in the process so nothing runs after the finish
        if (cycles == LIMIT)
        begin
            failures++;
            conclude();
        end
    end

    initial
    begin
        logic ok;
        int g0;
        logic [3:0] p;
        void'($urandom(32'h69db));
        ch1Lim = 8'(60 + $urandom % 100);
        ch4Lim = 8'(60 + $urandom % 100);
        res[0] = int'(ch1Lim) - 20;
        res[1] = int'($urandom % 256);
        res[2] = int'($urandom % 256);
        res[3] = int'(ch4Lim) - 20;
        repeat (20) @(posedge clock);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clock);
        rd(CMD_FAULT_STATUS, 8'h60);
        rd(CMD_OVT_STATUS, expOvt);
        rd(CMD_CFG1, 8'h00);
        rd(8'h15, 8'h00);
        wr(CMD_OVT_STATUS, 8'hFF);
        rd(CMD_OVT_STATUS, 8'h00);
        wr(CMD_CFG1, 8'h37);
        rd(CMD_CFG1, 8'h30);
        check({7'h0, rcEnable}, 8'h00, "cancellation off");
        wr(CMD_CFG1, 8'h00);
        i_host.write_reg(7'h2D, CMD_CFG1, 8'h08, ok);
        check({7'h0, ok}, 8'h00, "foreign address");
        // Channel 1 one above its limit, channel 4 exactly at it
        res[0] = int'(ch1Lim) + 1;
        res[3] = int'(ch4Lim);
        wait_starts(8);
        res[3] = int'(ch4Lim) + 1;
        wait_starts(8);
        // Inside the hysteresis band: no new sets, pin held
        res[0] = int'(ch1Lim) - 2;
        res[3] = int'(ch4Lim) - 4;
        wait_starts(8);
        rd(CMD_OVT_STATUS, expOvt);
        expOvt = 8'h00;
        rd(CMD_OVT_STATUS, expOvt);
        check({7'h0, overtempOutputOe}, 8'h01, "pin after read");
        res[0] = int'(ch1Lim) - 5;
        res[3] = int'(ch4Lim) - 5;
        wait_starts(8);
        check({7'h0, overtempOutputOe}, 8'h00, "pin released");
        rd(CMD_OVT_STATUS, expOvt);
        for (int i = 0; i < 5; i++)
        begin
            p = (i < 4) ? 4'(1 << i) : 4'($urandom % 15);
            faultReq = p;
            wait_starts(10);
            rd(CMD_FAULT_STATUS, 8'h60 | {3'h0, p, 1'b0});
        end
        faultReq = 4'h0;
        wait_starts(8);
        g0 = lastGap;
        wr(CMD_CFG1, 8'h08);
        rd(CMD_CFG1, 8'h08);
        check({7'h0, rcEnable}, 8'h01, "cancellation on");
        wait_starts(8);
        check(8'(lastGap - g0), 8'(RC_X), "extra conversion time");
        res[0] = int'(ch1Lim) + 3;
        wait_starts(8);
        res[0] = int'(ch1Lim) - 30;
        wait_starts(8);
        softPending = 1'b1;
        wr(CMD_CFG1, 8'h40);
        softPending = 1'b0;
        expOvt = 8'h00;
        rd(CMD_OVT_STATUS, expOvt);
        rd(CMD_CFG1, 8'h00);
        check({7'h0, rcEnable}, 8'h00, "cancellation after soft reset");
        rd(CMD_FAULT_STATUS, 8'h60);
        conclude();
    end
endmodule : testbench
`default_nettype wire
